// ==== actm_pkg.sv ====
// Shared constants for the converter clock and sample timing block
package actm_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int SRC_BIT = 15;
  localparam int RSVD_HI = 14;
  localparam int RSVD_LO = 13;
  localparam int SAMC_HI = 12;
  localparam int SAMC_LO = 8;
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 0;
  localparam logic [15:0] CTRL_WR_MASK = 16'h9fff;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_SRC_BIT = 1;
  localparam int STAT_REM_LO = 8;
  localparam int STAT_REM_HI = 12;
  localparam logic [7:0] DIV_LAST_VALID = 8'h3f;
  // Oscillator periods per instruction cycle
  localparam int TCY_OSC_PERIODS = 2;
endpackage : actm_pkg

// ==== actm_smp_if.sv ====
// Carrier between the timing control core and the sample timer
`timescale 1ns/1ps
`default_nettype none
interface actm_smp_if;
  logic conv_tick;
  logic start;
  logic [4:0] count;
  logic active;
  logic done;
  logic [4:0] remaining;
  modport timer (
    input conv_tick, start, count,
    output active, done, remaining
  );
  modport core (
    output conv_tick, start, count,
    input active, done, remaining
  );
endinterface : actm_smp_if
`default_nettype wire

// ==== actm_sample_timer.sv ====
// Automatic sample interval timer counted in conversion clock periods
`timescale 1ns/1ps
`default_nettype none
module actm_sample_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to core
  actm_smp_if.timer smp
);
  logic active_q;
  logic done_q;
  logic [4:0] rem_q;
  wire logic idle_start = smp.start && !active_q;
  wire logic last_tick = active_q && smp.conv_tick && rem_q == 5'h01;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
      done_q <= 1'b0;
      rem_q <= 5'h00;
    end else begin
      done_q <= 1'b0;
      if (idle_start) begin
        // Zero setting: no sample time at all
        active_q <= (smp.count != 5'h00);
        done_q <= (smp.count == 5'h00);
        rem_q <= smp.count;
      end else if (last_tick) begin
        active_q <= 1'b0;
        done_q <= 1'b1;
        rem_q <= 5'h00;
      end else if (active_q && smp.conv_tick) begin
        rem_q <= rem_q - 5'h01;
      end
    end
  end

  assign smp.active = active_q;
  assign smp.done = done_q;
  assign smp.remaining = rem_q;

  a_zero_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_start && smp.count == 5'h00 |=> done_q && !active_q)
    else $error("zero sample count did not finish at once");
  a_sample_end: assert property (@(posedge clk_i) disable iff (rst_i)
    last_tick ##1 !idle_start |-> done_q && !active_q ##1 !done_q)
    else $error("sample did not end on final conversion period");
  a_sample_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    active_q && !smp.conv_tick |=> active_q && $stable(rem_q))
    else $error("sample interval moved without a conversion tick");
endmodule : actm_sample_timer
`default_nettype wire

// ==== actm_timing_ctrl.sv ====
// Converter clock source, divider and sample timing with Wishbone registers
//
// Summary of operation
// - Source bit picks RC or system-derived clock
// - Sample interval equals count in conversion periods
// - Divider code plus one instruction cycles
// - Instruction cycle is two oscillator periods
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module actm_timing_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Converter side
  input wire logic rc_tick_i,
  input wire logic sample_start_i,
  output logic conv_tick_o,
  output logic sample_active_o,
  output logic sample_done_o
);
  logic [15:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic tcy_q;
  logic [7:0] div_cnt_q;
  logic conv_tick_q;

  actm_smp_if smp ();

  actm_sample_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .smp(smp)
  );

  // Bus decode
  wire logic bus_req = cyc_i && stb_i && !ack_q;
  wire logic hit_ctrl = adr_i == actm_pkg::CTRL_OFFSET;
  wire logic hit_status = adr_i == actm_pkg::STATUS_OFFSET;
  wire logic ctrl_wr = bus_req && we_i && hit_ctrl;
  wire logic [15:0] byte_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  // Reserved bits never store, so they always read back as zero
  wire logic [15:0] ctrl_d = ((ctrl_q & ~byte_mask)
    | (dat_i[15:0] & byte_mask)) & actm_pkg::CTRL_WR_MASK;

  wire logic clk_src_rc = ctrl_q[actm_pkg::SRC_BIT];
  wire logic [4:0] samc = ctrl_q[actm_pkg::SAMC_HI:actm_pkg::SAMC_LO];
  wire logic [7:0] div_code = ctrl_q[actm_pkg::DIV_HI:actm_pkg::DIV_LO];

  // Status fields placed by the shared positions
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[actm_pkg::STAT_ACTIVE_BIT] = smp.active;
    status_word[actm_pkg::STAT_SRC_BIT] = clk_src_rc;
    status_word[actm_pkg::STAT_REM_HI:actm_pkg::STAT_REM_LO] = smp.remaining;
  end
  logic [31:0] rdata_d;
  always_comb begin
    if (hit_ctrl) begin
      rdata_d = {16'h0000, ctrl_q};
    end else if (hit_status) begin
      rdata_d = status_word;
    end else begin
      rdata_d = 32'h00000000;
    end
  end

  // Instruction cycle enable from the oscillator clock
  wire logic tcy_en = tcy_q;
  // Reserved divider codes simply count longer; not guarded
  wire logic div_wrap = tcy_en && div_cnt_q >= div_code;
  wire logic conv_tick_d = clk_src_rc ? rc_tick_i : div_wrap;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= actm_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !we_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcy_q <= 1'b0;
      div_cnt_q <= 8'h00;
      conv_tick_q <= 1'b0;
    end else begin
      tcy_q <= ~tcy_q;
      if (div_wrap || clk_src_rc) begin
        div_cnt_q <= 8'h00;
      end else if (tcy_en) begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
      conv_tick_q <= conv_tick_d;
    end
  end

  assign smp.conv_tick = conv_tick_q;
  assign smp.start = sample_start_i;
  assign smp.count = samc;

  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign conv_tick_o = conv_tick_q;
  assign sample_active_o = smp.active;
  assign sample_done_o = smp.done;

  a_rc_source: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_src_rc && !ctrl_wr |=> conv_tick_q == $past(rc_tick_i))
    else $error("RC source not passed to conversion clock");
  a_sys_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && tcy_en && div_cnt_q == div_code |=> conv_tick_q)
    else $error("divider terminal count gave no conversion tick");
  a_sys_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && !(tcy_en && div_cnt_q >= div_code) |=> !conv_tick_q)
    else $error("conversion tick outside divider terminal count");
  a_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && div_code == 8'h00 && tcy_en && !ctrl_wr ##1 !ctrl_wr
    |-> conv_tick_q ##1 !conv_tick_q ##1 conv_tick_q)
    else $error("code zero is not one instruction cycle");
  a_tcy_period: assert property (@(posedge clk_i) disable iff (rst_i)
    tcy_en |=> !tcy_en ##1 tcy_en)
    else $error("instruction cycle is not two oscillator periods");
  a_reset_clear: assert property (@(posedge clk_i)
    $past(rst_i) |-> ctrl_q == 16'h0000 && !conv_tick_q)
    else $error("control register not cleared by reset");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr |=> ctrl_q[actm_pkg::RSVD_HI:actm_pkg::RSVD_LO] == 2'h0)
    else $error("reserved control bits stored a one");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus answer not a single cycle after request");

  // Register bus behaviour
  a_wr_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr
    |=> ctrl_q == $past(ctrl_d))
    else $error("control write did not land");

  a_no_stray_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_wr
    |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  a_status_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && we_i && !hit_ctrl
    |=> $stable(ctrl_q))
    else $error("write to other address changed control");

  a_lane_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && !sel_i[0]
    |=> $stable(ctrl_q[7:0]))
    else $error("low byte written without its select");

  a_lane_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && !sel_i[1]
    |=> $stable(ctrl_q[15:8]))
    else $error("high byte written without its select");

  a_rsvd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && dat_i[14:13] != 2'h0
    |=> ctrl_q[actm_pkg::RSVD_HI:actm_pkg::RSVD_LO] == 2'h0)
    else $error("reserved bits kept written ones");

  a_rd_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !we_i && hit_ctrl
    |=> dat_o == {16'h0000, $past(ctrl_q)})
    else $error("control read data wrong");

  a_rd_status: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !we_i && hit_status
    |=> dat_o == $past(status_word))
    else $error("status read data wrong");

  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !we_i && !hit_ctrl && !hit_status
    |=> dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  a_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(bus_req && !we_i)
    |=> $stable(dat_o))
    else $error("read data moved without a read");

  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_req
    |=> !ack_o)
    else $error("answer without a request");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("answer stood longer than one cycle");

  a_reset_outs: assert property (@(posedge clk_i)
    $past(rst_i)
    |-> !ack_o && dat_o == 32'h00000000 && !sample_active_o && !sample_done_o)
    else $error("outputs not quiet after reset");

  // Conversion clock path
  a_rc_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_src_rc
    |=> div_cnt_q == 8'h00)
    else $error("divider ran while RC source selected");

  a_rc_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_src_rc && !rc_tick_i
    |=> !conv_tick_q)
    else $error("tick from divider while RC source selected");

  a_rc_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && rc_tick_i && !div_wrap
    |=> !conv_tick_q)
    else $error("RC tick leaked into system source");

  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && conv_tick_q
    |=> !conv_tick_q)
    else $error("system tick longer than one cycle");

  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && tcy_en && div_cnt_q < div_code
    |=> div_cnt_q == $past(div_cnt_q) + 8'h01)
    else $error("divider did not step on instruction cycle");

  a_cnt_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !clk_src_rc && !tcy_en
    |=> $stable(div_cnt_q))
    else $error("divider stepped between instruction cycles");

  a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    div_wrap
    |=> div_cnt_q == 8'h00)
    else $error("divider did not restart after terminal count");

  a_tcy_first: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i
    |-> !tcy_en ##1 tcy_en)
    else $error("instruction cycle phase wrong after reset");

  // Sample interval hand-off
  a_start_takes: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.start && !smp.active && samc != 5'h00
    |=> smp.active && smp.remaining == $past(samc))
    else $error("sample start did not load the count");

  a_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.start && smp.active && !conv_tick_q
    |=> smp.active && $stable(smp.remaining))
    else $error("start while busy disturbed the interval");

  a_dec_one: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.active && conv_tick_q && smp.remaining > 5'h01
    |=> smp.active && smp.remaining == $past(smp.remaining) - 5'h01)
    else $error("sample count did not step on a tick");

  a_last_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.active && conv_tick_q && smp.remaining == 5'h01
    |=> !smp.active && smp.done)
    else $error("interval did not end on final tick");

  a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.done
    |-> !smp.active)
    else $error("done shown while interval runs");

  a_rem_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !smp.active
    |-> smp.remaining == 5'h00)
    else $error("count left over while idle");
endmodule : actm_timing_ctrl
`default_nettype wire

// ==== actm_timing_ctrl_tb.sv ====
// Self-checking testbench for the converter timing control block
`timescale 1ns/1ps
`default_nettype none
module actm_timing_ctrl_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0;
  logic rc_tick_i = 0, sample_start_i = 0;
  logic [31:0] dat_o;
  logic ack_o, conv_tick_o, sample_active_o, sample_done_o, last;
  logic [31:0] expq[$];
  logic [7:0] d;
  int n_fail = 0, n_tests = 0, seed = 41, k, t;
  actm_timing_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rc_tick_i(rc_tick_i),
    .sample_start_i(sample_start_i), .conv_tick_o(conv_tick_o),
    .sample_active_o(sample_active_o), .sample_done_o(sample_done_o));
  initial forever #50 clk_i = ~clk_i;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task lim(input int m);
    if (k >= m) begin
      n_fail++;
      end_of_test;
    end
  endtask : lim
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= v;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
    lim(20);
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task tick;
    k = 0;
    do begin @(posedge clk_i); k++; end while (conv_tick_o !== 1'b1 && k < 600);
    lim(600);
  endtask : tick
  task samp(input logic [4:0] n);
    bus(1'b1, actm_pkg::CTRL_OFFSET, {19'h0, n, 8'h00});
    @(posedge clk_i); sample_start_i <= 1;
    @(posedge clk_i); sample_start_i <= 0;
    t = 0; k = 0;
    do begin
      @(posedge clk_i); k++;
      if (sample_active_o && conv_tick_o) t++;
    end while (sample_done_o !== 1'b1 && k < 200);
    lim(200);
    chk(32'(t), {27'h0, n});
    chk({31'h0, sample_active_o}, 32'h0);
  endtask : samp
  // Read results are judged here when the answer shows up
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, expq.pop_front());
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(actm_pkg::CTRL_OFFSET, 32'h0);
    bus(1'b1, actm_pkg::CTRL_OFFSET, 32'hffff);
    rd(actm_pkg::CTRL_OFFSET, 32'h9fff);
    rd(8'h80, 32'h0);
    sel_i <= 4'h1;
    bus(1'b1, actm_pkg::CTRL_OFFSET, 32'h1234);
    sel_i <= 4'h3;
    rd(actm_pkg::CTRL_OFFSET, 32'h9f34);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      // Divider kept in the legal range
      d = (i == 0) ? 8'h00 : (i == 1) ? actm_pkg::DIV_LAST_VALID :
        8'($random(seed)) & actm_pkg::DIV_LAST_VALID;
      bus(1'b1, actm_pkg::CTRL_OFFSET, {24'h0, d});
      tick; tick; tick;
      chk(32'(k), 32'(actm_pkg::TCY_OSC_PERIODS * (d + 1)));
    end
    $display("divider test done");
    bus(1'b1, actm_pkg::CTRL_OFFSET, 32'h8000);
    rd(actm_pkg::STATUS_OFFSET, 32'h2);
    repeat (4) @(posedge clk_i);
    last = 0;
    repeat (60) begin
      @(posedge clk_i);
      chk({31'h0, conv_tick_o}, {31'h0, last});
      last = rc_tick_i;
      rc_tick_i <= 1'($random(seed));
    end
    rc_tick_i <= 0;
    $display("source test done");
    samp(5'd0);
    samp(5'd1);
    samp(5'd31);
    samp(5'($random(seed)));
    $display("sample test done");
    end_of_test;
  end
endmodule : actm_timing_ctrl_tb
`default_nettype wire
